// ==== fpp_flash_prot.sv ====
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module fpp_flash_prot
	import fpp_pkg::*;
#(
	parameter int unsigned SECTOR0_BYTES = 256
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic        prog_serial_clock_pin_i,
	output logic             prog_serial_clock_pin_o,
	output logic             prog_serial_clock_pin_oe,
	output logic             prog_serial_clock_pullup,
	input  wire logic        prog_serial_data_pin_i,
	output logic             prog_serial_data_pin_o,
	output logic             prog_serial_data_pin_oe,
	input  wire logic        reset_pin_n,
	input  wire logic        prog_socket_mode,
	input  wire fpp_opt_t    opt_in,
	output fpp_flash_t       flash_cmd,
	input  wire logic        flash_done,
	input  wire logic [7:0]  flash_rdata,
	output logic             ram_wr_valid,
	input  wire logic        ram_wr_ready,
	output fpp_rx_t          ram_wr,
	output logic [1:0]       clk_src_sel,
	output logic             boot_sysmem_vec,
	output logic             run_ram_driver,
	output logic             prog_pins_owned
);
	typedef struct packed {
		fpp_fsm_t                  fsm;
		logic [2:0]                c_op;
		logic [4:0]                c_len;
		logic [FL_AW-1:0]          a_reg;
		logic [ROW_BYTES-1:0][7:0] rowb;
		logic [4:0]                widx;
		logic [4:0]                cnt;
		fpp_opt_t                  opt;
		fpp_opt_t                  opt_new;
		logic                      valid;
		logic                      done;
		logic                      err;
		logic                      ovr;
		logic                      pend;
		logic [7:0]                rdata;
		fpp_flash_t                fl;
		logic [5:0]                pulses;
		logic                      icc;
		logic                      opt_en;
		logic [1:0]                clk_src;
		logic                      boot_sys;
		logic                      run_drv;
		logic                      run_out;
		logic                      owned;
		logic                      p_ck_o;
		logic                      p_ck_oe;
		logic                      p_dt_o;
		logic                      p_dt_oe;
		logic                      ck_oe;
		logic                      ck_pu;
		logic                      dt_oe;
		logic                      ck_prev;
		logic                      rst_prev;
		logic [2:0]                bitc;
		logic [6:0]                sh;
		logic [RAM_AW-1:0]         rxa;
		logic                      push;
		fpp_rx_t                   rx;
		logic                      wr;
		logic [7:0]                wa;
		logic [31:0]               hrdata;
		logic                      hready;
	} fpp_state_t;

	fpp_state_t s;
	fpp_state_t n;
	logic [3:0] sy;
	logic       ck_s;
	logic       dt_s;
	logic       rst_s;
	logic       sock_s;
	logic       ck_rise;
	logic       tool;
	logic       rx_ready;

	function automatic logic fpp_in_s0(input logic [FL_AW-1:0] a);
		return a < SECTOR0_BYTES[FL_AW-1:0];
	endfunction

	function automatic logic fpp_allowed(input logic [2:0] op, input logic [FL_AW-1:0] a, input logic tl,
			input fpp_opt_t o, input fpp_opt_t w);
		logic ok;
		ok = 1'b0;
		case (op)
			OP_PROG, OP_ERASE: ok = !o.wep && !o.rop && (tl || !fpp_in_s0(a));
			OP_READ: ok = !(tl && o.rop);
			OP_OPT: ok = tl && !(o.wep && o.rop && !w.rop);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Clock and reset pins idle high; they cross inverted so the cleared synchroniser shows the idle level.
	localparam logic [3:0] SY_INV = 4'ha;

	fpp_sync #(
		.W(4)
	) u_sync (
		.ref_clk(ref_clk),
		.resetn (resetn),
		.d      ({prog_serial_clock_pin_i, prog_serial_data_pin_i, reset_pin_n, prog_socket_mode} ^ SY_INV),
		.q      (sy)
	);

	assign {ck_s, dt_s, rst_s, sock_s} = sy ^ SY_INV;
	assign ck_rise = ck_s && !s.ck_prev;
	assign tool    = s.icc || sock_s;

	// Received bytes wait here until the RAM port takes them.
	fpp_skid2 #(
		.W($bits(fpp_rx_t))
	) u_buf (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.in_valid (s.push),
		.in_ready (rx_ready),
		.in_data  (s.rx),
		.out_valid(ram_wr_valid),
		.out_ready(ram_wr_ready),
		.out_data (ram_wr)
	);

	always_comb begin
		logic start;
		start         = 1'b0;
		n             = s;
		n.fl.req      = 1'b0;
		n.fl.latch    = 1'b0;
		n.wr          = 1'b0;
		n.hready      = 1'b1;
		// Register writes land in the data phase; hardware sets below win over clears.
		if (s.wr) begin
			case (s.wa)
				A_CTRL: begin
					n.c_op  = hwdata[C_OP+:3];
					n.c_len = hwdata[C_LEN+:5];
					start   = hwdata[C_START];
				end
				A_ADDR: n.a_reg = hwdata[FL_AW-1:0];
				A_DATA: begin
					n.rowb[s.widx] = hwdata[7:0];
					n.widx         = s.widx + 5'h01;
				end
				A_STAT: begin
					n.done = s.done && !hwdata[S_DONE];
					n.err  = s.err && !hwdata[S_ERR];
					n.ovr  = s.ovr && !hwdata[S_OVR];
				end
				A_OPT: n.opt_new = hwdata[$bits(fpp_opt_t)-1:0];
				A_PIN: begin
					n.p_ck_o  = hwdata[P_CK_O];
					n.p_ck_oe = hwdata[P_CK_OE];
					n.p_dt_o  = hwdata[P_DT_O];
					n.p_dt_oe = hwdata[P_DT_OE];
					n.run_drv = hwdata[P_RUN];
				end
				default: ;
			endcase
		end
		// The option byte is caught once, in the first cycle after reset.
		if (!s.valid) begin
			n.opt   = opt_in;
			n.valid = 1'b1;
		end
		// Pulses on the clock pin are counted while the reset pin is held low.
		n.ck_prev  = ck_s;
		n.rst_prev = rst_s;
		if (!rst_s) begin
			if (ck_rise && (s.pulses != 6'h3f)) begin
				n.pulses = s.pulses + 6'h01;
			end
		end else if (!s.rst_prev) begin
			n.pulses = '0;
			if (!s.icc && (s.pulses == PULSES_NO_OPT)) begin
				n.icc     = 1'b1;
				n.opt_en  = 1'b0;
				n.clk_src = CS_EXT;
			end else if (!s.icc && (s.pulses == PULSES_OPT)) begin
				n.icc     = 1'b1;
				n.opt_en  = 1'b1;
				n.clk_src = (s.opt.ck == CK_IRC) ? CS_IRC : CS_LFRC;
			end
		end else if (s.icc && ck_rise) begin
			n.sh   = {s.sh[5:0], dt_s};
			n.bitc = s.bitc + 3'h1;
			if (s.bitc == 3'h7) begin
				if (s.push && !rx_ready) begin
					n.ovr = 1'b1;
				end else begin
					n.push    = 1'b1;
					n.rx.addr = s.rxa;
					n.rx.data = {s.sh, dt_s};
					n.rxa     = s.rxa + 7'h01;
				end
			end
		end
		if (s.push && rx_ready && (n.rx == s.rx)) begin
			n.push = 1'b0;
		end
		n.boot_sys = n.icc;
		n.owned    = n.icc;
		n.run_out  = n.run_drv && n.icc;
		n.ck_oe    = s.p_ck_oe && !n.icc;
		n.dt_oe    = s.p_dt_oe && !n.icc;
		n.ck_pu    = !n.ck_oe;
		unique case (s.fsm)
			FS_IDLE: begin
				if (start) begin
					if (!s.valid || !fpp_allowed(n.c_op, s.a_reg, tool, s.opt, s.opt_new)) begin
						n.err = 1'b1;
					end else begin
						n.fl.op    = n.c_op;
						n.fl.addr  = s.a_reg;
						n.fl.wdata = {4'h0, s.opt_new};
						n.cnt      = '0;
						if (n.c_op == OP_PROG) begin
							n.fsm = FS_LOAD;
						end else if ((n.c_op == OP_OPT) && s.opt.rop && !s.opt_new.rop) begin
							n.fl.op  = OP_MASS;
							n.pend   = 1'b1;
							n.fl.req = 1'b1;
							n.fsm    = FS_WAIT;
						end else begin
							n.fl.req = 1'b1;
							n.fsm    = FS_WAIT;
						end
					end
				end
			end
			FS_LOAD: begin
				if (start) begin
					n.err = 1'b1;
				end
				n.fl.latch = 1'b1;
				n.fl.idx   = s.fl.addr[4:0] + s.cnt;
				n.fl.wdata = s.rowb[s.cnt];
				n.cnt      = s.cnt + 5'h01;
				if (s.cnt == s.c_len) begin
					n.fl.req = 1'b1;
					n.fsm    = FS_WAIT;
				end
			end
			FS_WAIT: begin
				if (start) begin
					n.err = 1'b1;
				end
				if (flash_done) begin
					if (s.pend) begin
						n.pend     = 1'b0;
						n.fl.op    = OP_OPT;
						n.fl.wdata = {4'h0, s.opt_new};
						n.fl.req   = 1'b1;
					end else begin
						n.fsm  = FS_IDLE;
						n.done = 1'b1;
						n.widx = '0;
						if (s.fl.op == OP_READ) begin
							n.rdata = flash_rdata;
						end
						if (s.fl.op == OP_OPT) begin
							n.opt.rop = s.opt_new.rop;
							n.opt.wep = s.opt.wep || s.opt_new.wep;
							n.opt.ck  = s.opt_new.ck;
						end
					end
				end
			end
			default: n.fsm = FS_IDLE;
		endcase
		// Address phase: reads are answered from the state seen at this edge.
		if (hsel && htrans[1] && hready) begin
			n.wr     = hwrite;
			n.wa     = haddr[7:0];
			n.hrdata = '0;
			if (!hwrite) begin
				case (haddr[7:0])
					A_CTRL: begin
						n.hrdata[C_OP+:3]  = s.c_op;
						n.hrdata[C_LEN+:5] = s.c_len;
					end
					A_ADDR: n.hrdata[FL_AW-1:0] = s.a_reg;
					A_STAT: begin
						n.hrdata[S_BUSY]  = (s.fsm != FS_IDLE);
						n.hrdata[S_DONE]  = s.done;
						n.hrdata[S_ERR]   = s.err;
						n.hrdata[S_ICC]   = s.icc;
						n.hrdata[S_OPTEN] = s.opt_en;
						n.hrdata[S_ROP]   = s.opt.rop;
						n.hrdata[S_WEP]   = s.opt.wep;
						n.hrdata[S_OVR]   = s.ovr;
						n.hrdata[S_VALID] = s.valid;
					end
					A_OPT: n.hrdata[$bits(fpp_opt_t)-1:0] = s.opt_new;
					A_PIN: begin
						n.hrdata[P_CK_O]  = s.p_ck_o;
						n.hrdata[P_CK_OE] = s.p_ck_oe;
						n.hrdata[P_DT_O]  = s.p_dt_o;
						n.hrdata[P_DT_OE] = s.p_dt_oe;
						n.hrdata[P_RUN]   = s.run_drv;
					end
					A_RDAT: n.hrdata[7:0] = s.rdata;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s        <= '0;
			s.fsm    <= FS_IDLE;
			s.ck_pu  <= 1'b1;
			s.ck_prev  <= 1'b1;
			s.rst_prev <= 1'b1;
			s.hready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign hreadyout                = s.hready;
	assign hrdata                   = s.hrdata;
	assign hresp                    = 1'b0;
	assign prog_serial_clock_pin_o  = s.p_ck_o;
	assign prog_serial_clock_pin_oe = s.ck_oe;
	assign prog_serial_clock_pullup = s.ck_pu;
	assign prog_serial_data_pin_o   = s.p_dt_o;
	assign prog_serial_data_pin_oe  = s.dt_oe;
	assign flash_cmd                = s.fl;
	assign clk_src_sel              = s.clk_src;
	assign boot_sysmem_vec          = s.boot_sys;
	assign run_ram_driver           = s.run_out;
	assign prog_pins_owned          = s.owned;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	user_sector0_a: assert property ((s.fl.req && ((s.fl.op == OP_PROG) || (s.fl.op == OP_ERASE)) && !tool)
		|-> !fpp_in_s0(s.fl.addr)) else $error("sector 0 changed outside tool mode");
	wep_block_a: assert property ((s.fl.req && ((s.fl.op == OP_PROG) || (s.fl.op == OP_ERASE)
		|| (s.fl.op == OP_MASS))) |-> !s.opt.wep) else $error("change issued under write protection");
	wep_sticky_a: assert property (s.opt.wep |=> s.opt.wep [*3]) else $error("write protection cleared");
	rop_block_a: assert property ((s.fl.req && ((s.fl.op == OP_PROG) || (s.fl.op == OP_ERASE)))
		|-> !s.opt.rop) else $error("write issued under readout protection");
	mass_first_a: assert property ((s.fl.req && (s.fl.op == OP_MASS)) |-> s.pend ##1 (s.fsm == FS_WAIT))
		else $error("mass erase not followed by option write");
	opt_first_a: assert property (!s.valid |=> s.valid && !$past(s.fl.req)) else $error("options not sampled");
	entry_ext_a: assert property (($rose(s.icc) && !s.opt_en) |-> (s.clk_src == CS_EXT) && $past(s.pulses)
		== PULSES_NO_OPT) else $error("35-pulse entry wrong");
	rc_force_a: assert property (($rose(s.icc) && s.opt_en) |-> (s.clk_src != CS_EXT))
		else $error("external clock kept in option entry");
	rc_pick_a: assert property (($rose(s.icc) && s.opt_en) |-> (s.clk_src == ((s.opt.ck == CK_IRC) ? CS_IRC
		: CS_LFRC))) else $error("wrong internal oscillator");
	boot_vec_a: assert property ($rose(s.icc) |-> s.boot_sys ##1 s.boot_sys) else $error("reset vector not set");
	pins_owned_a: assert property (s.icc |-> !s.ck_oe && !s.dt_oe && s.owned) else $error("pins left to app");
	clk_pullup_a: assert property (!s.valid |-> s.ck_pu && !s.ck_oe) else $error("clock pin not input");
	rx_hold_a: assert property ((s.push && !rx_ready) |=> s.push && $stable(s.rx)) else $error("byte dropped");
	row_issue_a: assert property (((s.fsm == FS_LOAD) && (s.cnt == s.c_len)) |=> s.fl.req && s.fl.latch
		&& (s.fsm == FS_WAIT)) else $error("row program not issued");

	entry38_c: cover property ($rose(s.icc) && s.opt_en);
	row32_c: cover property (s.fl.req && (s.fl.op == OP_PROG) && (s.c_len == 5'h1f));
	mass_c: cover property (s.fl.req && (s.fl.op == OP_MASS));
	stall_c: cover property (s.push && !rx_ready);
endmodule // fpp_flash_prot

// ==== fpp_pkg.sv ====
package fpp_pkg;
	localparam int unsigned ROW_BYTES     = 32;
	localparam int unsigned FL_AW         = 10;
	localparam int unsigned RAM_AW        = 7;
	localparam logic [5:0]  PULSES_NO_OPT = 6'h23;
	localparam logic [5:0]  PULSES_OPT    = 6'h26;

	localparam logic [7:0]  A_CTRL = 8'h00;
	localparam logic [7:0]  A_ADDR = 8'h04;
	localparam logic [7:0]  A_DATA = 8'h08;
	localparam logic [7:0]  A_STAT = 8'h0c;
	localparam logic [7:0]  A_OPT  = 8'h10;
	localparam logic [7:0]  A_PIN  = 8'h14;
	localparam logic [7:0]  A_RDAT = 8'h18;

	localparam int unsigned C_START = 0;
	localparam int unsigned C_OP    = 1;
	localparam int unsigned C_LEN   = 8;

	localparam int unsigned S_BUSY  = 0;
	localparam int unsigned S_DONE  = 1;
	localparam int unsigned S_ERR   = 2;
	localparam int unsigned S_ICC   = 3;
	localparam int unsigned S_OPTEN = 4;
	localparam int unsigned S_ROP   = 5;
	localparam int unsigned S_WEP   = 6;
	localparam int unsigned S_OVR   = 7;
	localparam int unsigned S_VALID = 8;

	localparam int unsigned P_CK_O  = 0;
	localparam int unsigned P_CK_OE = 1;
	localparam int unsigned P_DT_O  = 2;
	localparam int unsigned P_DT_OE = 3;
	localparam int unsigned P_RUN   = 4;

	localparam logic [2:0]  OP_PROG  = 3'h1;
	localparam logic [2:0]  OP_ERASE = 3'h2;
	localparam logic [2:0]  OP_READ  = 3'h3;
	localparam logic [2:0]  OP_OPT   = 3'h4;
	localparam logic [2:0]  OP_MASS  = 3'h5;

	localparam logic [1:0]  CK_IRC  = 2'h0;
	localparam logic [1:0]  CK_LFRC = 2'h1;
	localparam logic [1:0]  CK_EXT  = 2'h2;

	localparam logic [1:0]  CS_OPT  = 2'h0;
	localparam logic [1:0]  CS_EXT  = 2'h1;
	localparam logic [1:0]  CS_IRC  = 2'h2;
	localparam logic [1:0]  CS_LFRC = 2'h3;

	typedef struct packed {
		logic       rop;
		logic       wep;
		logic [1:0] ck;
	} fpp_opt_t;

	typedef struct packed {
		logic [RAM_AW-1:0] addr;
		logic [7:0]        data;
	} fpp_rx_t;

	typedef struct packed {
		logic             req;
		logic             latch;
		logic [2:0]       op;
		logic [FL_AW-1:0] addr;
		logic [4:0]       idx;
		logic [7:0]       wdata;
	} fpp_flash_t;

	typedef enum logic [2:0] {
		FS_IDLE = 3'h1,
		FS_LOAD = 3'h2,
		FS_WAIT = 3'h4
	} fpp_fsm_t;
endpackage

// ==== fpp_sync.sv ====
`timescale 1ns/10ps
module fpp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} fpp_sync_t;

	fpp_sync_t s;
	fpp_sync_t n;

	always_comb begin
		n.meta = d;
		n.sync = s.meta;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q = s.sync;
endmodule // fpp_sync

// ==== fpp_skid2.sv ====
`timescale 1ns/10ps
module fpp_skid2 #(
	parameter int unsigned W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wp;
		logic              rp;
		logic [1:0]        cnt;
		logic              ov;
	} fpp_buf_t;

	fpp_buf_t s;
	fpp_buf_t n;

	always_comb begin
		logic push;
		logic pop;
		push = in_valid && (s.cnt != 2'h2);
		pop  = s.ov && out_ready;
		n    = s;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp        = ~s.wp;
		end
		if (pop) begin
			n.rp = ~s.rp;
		end
		n.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
		n.ov  = (n.cnt != 2'h0);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign in_ready  = (s.cnt != 2'h2);
	assign out_valid = s.ov;
	assign out_data  = s.mem[s.rp];
endmodule // fpp_skid2

// ==== fpp_tool_model.sv ====
`timescale 1ns/10ps
module fpp_tool_model (
	output logic ck,
	output logic dt,
	output logic rst_n
);
	initial begin
		ck = 1'b1;
		dt = 1'b1;
		rst_n = 1'b1;
	end

	// The device reset pin stays low for the whole pulse train, so no other reset can interfere.
	task automatic enter(input int n);
		rst_n = 1'b0;
		#1130;
		repeat (n) begin
			ck = 1'b0;
			#400;
			ck = 1'b1;
			#400;
		end
		// With 35 pulses the tool also feeds the external clock input; only the source choice is visible here.
		#1000;
		rst_n = 1'b1;
		#2000;
	endtask

	// Bytes go out most significant bit first, one bit per clock rise.
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			ck = 1'b0;
			dt = b[i];
			#400;
			ck = 1'b1;
			#400;
		end
		// A released data line shows the inverse of the last bit, never a stale copy.
		dt = ~b[0];
	endtask
endmodule // fpp_tool_model

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import fpp_pkg::*;
	logic        ref_clk = 0, resetn = 0, hsel = 1, hwrite = 0, flash_done = 0, ram_wr_ready = 0, sock = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0, clk_src_sel, dly = 0;
	logic [2:0]  hsize = 3'h2;
	logic [2:0]  ops [0:63];
	fpp_opt_t    opt_in = 0;
	fpp_flash_t  flash_cmd;
	fpp_rx_t     ram_wr;
	logic        hreadyout, hresp, ck_o, ck_oe, ck_pu, dt_o, dt_oe, t_ck, t_dt, t_rst_n;
	logic        ram_wr_valid, boot_vec, run_drv, owned;
	int          n_mismatch = 0, compares = 0, nops = 0, nlat = 0;

	always #50 ref_clk = ~ref_clk;

	fpp_tool_model i_tool (.ck(t_ck), .dt(t_dt), .rst_n(t_rst_n));

	fpp_flash_prot i_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .prog_serial_clock_pin_i(ck_oe ? ck_o : t_ck),
		.prog_serial_clock_pin_o(ck_o), .prog_serial_clock_pin_oe(ck_oe), .prog_serial_clock_pullup(ck_pu),
		.prog_serial_data_pin_i(dt_oe ? dt_o : t_dt), .prog_serial_data_pin_o(dt_o),
		.prog_serial_data_pin_oe(dt_oe), .reset_pin_n(t_rst_n), .prog_socket_mode(sock), .opt_in(opt_in),
		.flash_cmd(flash_cmd), .flash_done(flash_done), .flash_rdata(8'h5a), .ram_wr_valid(ram_wr_valid),
		.ram_wr_ready(ram_wr_ready), .ram_wr(ram_wr), .clk_src_sel(clk_src_sel), .boot_sysmem_vec(boot_vec),
		.run_ram_driver(run_drv), .prog_pins_owned(owned));

	// Flash macro stand-in: records each operation and answers it three cycles later.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nops <= 0;
			nlat <= 0;
			dly <= 2'h0;
			flash_done <= 1'b0;
		end else begin
			flash_done <= (dly == 2'h1);
			if (dly != 2'h0)
				dly <= dly - 2'h1;
			if (flash_cmd.req) begin
				ops[nops[5:0]] <= flash_cmd.op;
				nops <= nops + 1;
				dly <= 2'h3;
			end
			if (flash_cmd.latch)
				nlat <= nlat + 1;
		end
	end

	task automatic give_verdict;
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bail(input int n, input int lim);
		if (n >= lim) begin
			n_mismatch++;
			give_verdict;
		end
	endtask

	task automatic rdy_wait;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		bail(n, 50);
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		rdy_wait;
		htrans <= 2'h0;
		hwdata <= d;
		rdy_wait;
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0, r);
	endtask

	function automatic logic [31:0] ctl(input logic [2:0] op, input logic [4:0] len);
		return {19'h0, len, 4'h0, op, 1'b1};
	endfunction

	task automatic do_reset(input logic [3:0] o, input logic s);
		@(posedge ref_clk);
		resetn <= 1'b0;
		opt_in <= o;
		sock <= s;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
	endtask

	// Starts one flash operation and checks whether it finished cleanly or was refused.
	task automatic run_op(input logic [31:0] c, input logic [9:0] adr, input logic e, input string nm);
		logic [31:0] s;
		int n;
		wr(A_ADDR, {22'h0, adr});
		wr(A_CTRL, c);
		n = 0;
		do begin
			rd(A_STAT, s);
			n++;
		end while (s[S_BUSY] !== 1'b0 && n < 60);
		bail(n, 60);
		chk(nm, {30'h0, e, ~e}, {30'h0, s[S_ERR], s[S_DONE]});
		wr(A_STAT, 32'h86);
	endtask

	task automatic t_reset;
		logic [31:0] s;
		do_reset(4'h0, 1'b0);
		rd(A_STAT, s);
		chk("options valid", 32'h1, {31'h0, s[S_VALID]});
		rd(8'hfc, s);
		chk("unmapped read", 32'h0, s);
		wr(A_PIN, 32'hf);
		@(posedge ref_clk);
		#1;
		chk("pins driven", 32'h17, {27'h0, ck_oe, ck_pu, ck_o, dt_oe, dt_o});
		do_reset(4'h0, 1'b0);
		#1;
		chk("clock pin after reset", 32'h1, {30'h0, ck_oe, ck_pu});
	endtask

	task automatic t_user;
		logic [31:0] s;
		int l0;
		run_op(ctl(OP_PROG, 5'd0), 10'h000, 1'b1, "user prog sector0");
		for (int i = 0; i < 32; i++)
			wr(A_DATA, i);
		l0 = nlat;
		run_op(ctl(OP_PROG, 5'd31), 10'h100, 1'b0, "user row prog");
		chk("row latches", 32, nlat - l0);
		chk("row tail", 32'h1f1f, {19'h0, flash_cmd.idx, flash_cmd.wdata});
		run_op(ctl(OP_ERASE, 5'd0), 10'h140, 1'b0, "user sector erase");
		chk("erase op", {29'h0, OP_ERASE}, {29'h0, ops[nops - 1]});
		chk("erase addr", 32'h140, {22'h0, flash_cmd.addr});
		run_op(ctl(OP_READ, 5'd0), 10'h005, 1'b0, "user read");
		rd(A_RDAT, s);
		chk("read data", 32'h5a, s);
	endtask

	task automatic t_rop;
		logic [31:0] s;
		int n0;
		do_reset(4'h8, 1'b1);
		run_op(ctl(OP_PROG, 5'd0), 10'h100, 1'b1, "prog under rop");
		run_op(ctl(OP_READ, 5'd0), 10'h100, 1'b1, "tool read under rop");
		rd(A_STAT, s);
		chk("rop alone", 32'h2, {30'h0, s[S_ROP], s[S_WEP]});
		wr(A_OPT, 32'h0);
		n0 = nops;
		run_op(ctl(OP_OPT, 5'd0), 10'h000, 1'b0, "clear rop");
		chk("mass erase first", {26'h0, OP_MASS, OP_OPT}, {26'h0, ops[n0], ops[n0 + 1]});
		rd(A_STAT, s);
		chk("rop cleared", 32'h0, {31'h0, s[S_ROP]});
		run_op(ctl(OP_PROG, 5'd0), 10'h000, 1'b0, "socket prog sector0");
	endtask

	task automatic t_wep;
		logic [31:0] s;
		do_reset(4'h4, 1'b1);
		run_op(ctl(OP_PROG, 5'd0), 10'h100, 1'b1, "prog under wep");
		run_op(ctl(OP_ERASE, 5'd0), 10'h100, 1'b1, "erase under wep");
		wr(A_OPT, 32'h0);
		run_op(ctl(OP_OPT, 5'd0), 10'h000, 1'b0, "option under wep");
		rd(A_STAT, s);
		chk("wep alone", 32'h1, {30'h0, s[S_ROP], s[S_WEP]});
	endtask

	task automatic t_entry(input int n, input logic [1:0] ck, input logic [1:0] sel);
		logic [31:0] s;
		do_reset({2'h0, ck}, 1'b0);
		#30;
		i_tool.enter(n);
		#1;
		chk("clock source", {30'h0, sel}, {30'h0, clk_src_sel});
		chk("vector and pins", 32'h3, {30'h0, boot_vec, owned});
		rd(A_STAT, s);
		chk("mode bits", {30'h0, n == 38, 1'b1}, {30'h0, s[S_OPTEN], s[S_ICC]});
		wr(A_PIN, 32'h1a);
		@(posedge ref_clk);
		#1;
		chk("pins kept", 32'h1, {29'h0, ck_oe, dt_oe, run_drv});
		run_op(ctl(OP_PROG, 5'd0), 10'h000, 1'b0, "tool prog sector0");
	endtask

	task automatic t_link;
		logic [31:0] s;
		int n;
		#30;
		i_tool.send(8'ha5);
		i_tool.send(8'h3c);
		i_tool.send(8'hf0);
		// Two words fill the buffer and one waits in the push slot, so the fourth byte is dropped.
		i_tool.send(8'h0f);
		n = 0;
		while (ram_wr_valid !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		bail(n, 20);
		chk("ram word 1", {17'h0, 7'h00, 8'ha5}, {17'h0, ram_wr});
		rd(A_STAT, s);
		chk("overrun", 32'h1, {31'h0, s[S_OVR]});
		@(posedge ref_clk);
		ram_wr_ready <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("ram word 2", {16'h0, 1'b1, 7'h01, 8'h3c}, {16'h0, ram_wr_valid, ram_wr});
		@(posedge ref_clk);
		#1;
		chk("ram word 3", {16'h0, 1'b1, 7'h02, 8'hf0}, {16'h0, ram_wr_valid, ram_wr});
		@(posedge ref_clk);
		#1;
		chk("buffer empty", 32'h0, {31'h0, ram_wr_valid});
		@(posedge ref_clk);
		ram_wr_ready <= 1'b0;
	endtask

	initial begin
		#5000000;
		n_mismatch++;
		give_verdict;
	end

	initial begin
		t_reset;
		t_user;
		t_rop;
		t_wep;
		t_entry(38, CK_IRC, CS_IRC);
		t_link;
		t_entry(38, CK_LFRC, CS_LFRC);
		t_entry(38, CK_EXT, CS_LFRC);
		t_entry(35, CK_IRC, CS_EXT);
		give_verdict;
	end
endmodule // tb_top
